// ### src/sdc_cmd_if.sv
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Command comes from row, column and write strobes plus chip select.
// - Every input but the asynchronous reset is sampled and every output registered on the clock edge.
// - The burst column counter steps once per clock with the clock gate high during a burst, and holds while the burst is suspended.
// - Clock gate low enters power-down, self refresh, or suspends a burst.
// - Clock gate is seen at once while in power-down or self refresh.
// - Inputs are ignored while in power-down or self refresh.
// - Commands are decoded only when chip select is registered low.
// - Write data of a lane whose byte mask is high is discarded.
// - Byte mask high on a read turns that lane off two clocks later.
// - Bank select picks the bank of activate, read, write and precharge.
// - Row address comes with activate, column address with read and write.
// - Address bit ten on read or write requests auto precharge.
// - Precharge with bit ten low closes one bank, high closes all.
// - Mode register set loads the op-code from the address lines only with all banks closed and no burst running.
// - Column address is 8 or 9 bits wide by module size.
// - Mode fields: length, type, latency, operating mode, write burst mode.
module sdc_cmd_if
   import sdc_pkg::*;
#(
   parameter int ROW_W = 13,
   parameter int COL_W = 9,
   parameter int MEM_CW = 4,
   parameter int WFIFO_DEPTH = FIFO_DEPTH
)
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic chip_select_lo_n,
   input wire logic chip_select_hi_n,
   input wire logic row_strobe_n,
   input wire logic col_strobe_n,
   input wire logic write_strobe_n,
   input wire logic clock_gate_in,
   input wire logic bank_select_0,
   input wire logic bank_select_1,
   input wire logic [ROW_W-1:0] addr,
   input wire logic [LANES-1:0] byte_mask,
   input wire logic [DATA_W-1:0] data_lines_in,
   output logic [DATA_W-1:0] data_lines_out,
   output logic [LANES-1:0] data_lines_oe,
   output logic [BANKS-1:0] bank_open,
   output logic [ADDR_MAX_W-1:0] mode_word,
   output logic power_down,
   output logic self_refresh,
   output logic clock_suspended,
   output logic wr_fifo_space,
   output logic wr_overrun
);

   localparam int IDX_W = 2 + MEM_CW;
   localparam int MEM_DEPTH = 1 << IDX_W;
   localparam int FW = LANES + IDX_W + DATA_W;

   typedef struct packed {
      sdc_st_t st;
      logic pdown;
      logic sref;
      logic susp;
      logic [ADDR_MAX_W-1:0] mode;
      logic [BANKS-1:0] open;
      logic bact;
      logic bwr;
      logic [1:0] bbank;
      logic [COL_MAX_W-1:0] bstart;
      logic [COL_MAX_W-1:0] bcnt;
      logic bap;
      logic p1v;
      logic [DATA_W-1:0] p1d;
      logic p2v;
      logic [DATA_W-1:0] p2d;
      logic [LANES-1:0] m1;
      logic [DATA_W-1:0] outd;
      logic [LANES-1:0] oe;
      logic wspace;
      logic ovf;
   } sdc_state_t;

   sdc_state_t s;
   sdc_state_t n;

   logic live;
   logic [2:0] cmd;
   logic [1:0] bsel;
   logic [COL_MAX_W-1:0] col_in;
   logic [COL_MAX_W-1:0] full_mask;
   logic go;
   logic wr;
   logic [1:0] bk;
   logic [COL_MAX_W-1:0] st0;
   logic [COL_MAX_W-1:0] cnt;
   logic ap;
   logic [COL_MAX_W-1:0] bm;
   logic [COL_MAX_W-1:0] col;
   logic last;
   logic rd_cl3;
   logic beat_rd;
   logic push;
   logic [IDX_W-1:0] idx;
   logic [DATA_W-1:0] mem_q;
   logic f_in_ready;
   logic f_out_valid;
   logic [FW-1:0] f_out;
   logic [LANES-1:0] f_mask;
   logic [IDX_W-1:0] f_idx;
   logic [DATA_W-1:0] f_data;

   // ----------------------------------------------------------------
   // Command capture
   // ----------------------------------------------------------------
   // The module is one rank, so a low on either select takes the command.
   assign live = !(chip_select_lo_n && chip_select_hi_n);
   assign cmd = {row_strobe_n, col_strobe_n, write_strobe_n};
   assign bsel = {bank_select_1, bank_select_0};
   assign col_in = COL_MAX_W'(addr[COL_W-1:0]);
   assign full_mask = COL_MAX_W'((1 << COL_W) - 1);
   assign rd_cl3 = (s.mode[CL_MSB:CL_LSB] == CL_THREE);

   function automatic logic [COL_MAX_W-1:0] len_mask(input logic [2:0] bl,
                                                      input logic [COL_MAX_W-1:0] fm);
      case (bl)
         3'h0: len_mask = 9'h000;
         3'h1: len_mask = 9'h001;
         3'h2: len_mask = 9'h003;
         3'h3: len_mask = 9'h007;
         BL_FULL: len_mask = fm;
         default: len_mask = 9'h000;
      endcase
   endfunction : len_mask

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      n = s;
      go = s.bact;
      wr = s.bwr;
      bk = s.bbank;
      st0 = s.bstart;
      cnt = s.bcnt;
      ap = s.bap;
      bm = '0;
      col = '0;
      last = 1'b0;
      beat_rd = 1'b0;
      push = 1'b0;
      n.wspace = f_in_ready;
      case (s.st)
         S_PDOWN, S_SREF:
         begin
            // Buffers are off, so only the gate input is looked at.
            if (clock_gate_in)
            begin
               n.st = S_RUN;
            end
            n.oe = '0;
            n.p1v = 1'b0;
            n.p2v = 1'b0;
         end
         S_RUN:
         begin
            if (!clock_gate_in && s.bact)
            begin
               n.susp = 1'b1;
            end
            else if (!clock_gate_in)
            begin
               n.st = (live && cmd == CMD_REF) ? S_SREF : S_PDOWN;
               n.oe = '0;
            end
            else
            begin
               n.susp = 1'b0;
               if (live && (cmd == CMD_RD || cmd == CMD_WR) && s.open[bsel])
               begin
                  go = 1'b1;
                  wr = (cmd == CMD_WR);
                  bk = bsel;
                  st0 = col_in;
                  cnt = '0;
                  ap = addr[AP_BIT];
               end
               bm = len_mask(s.mode[BL_MSB:BL_LSB], full_mask);
               if (wr && s.mode[WBM_BIT])
               begin
                  bm = '0;
               end
               if (s.mode[BT_BIT])
               begin
                  col = (st0 & ~bm) | ((st0 ^ cnt) & bm);
               end
               else
               begin
                  col = (st0 & ~bm) | ((st0 + cnt) & bm);
               end
               // A full page burst wraps until terminated.
               last = (cnt == bm) && !(bm == full_mask && bm != '0);
               if (go)
               begin
                  n.bwr = wr;
                  n.bbank = bk;
                  n.bstart = st0;
                  n.bcnt = cnt + 1'b1;
                  n.bap = ap;
                  n.bact = !last;
                  if (last && ap)
                  begin
                     n.open[bk] = 1'b0;
                  end
                  if (wr)
                  begin
                     // Fully masked beats never reach the array.
                     push = f_in_ready && (byte_mask != '1);
                     if (!f_in_ready && byte_mask != '1)
                     begin
                        n.ovf = 1'b1;
                     end
                  end
                  else
                  begin
                     beat_rd = 1'b1;
                  end
               end
               if (live)
               begin
                  case (cmd)
                     CMD_ACT:
                     begin
                        n.open[bsel] = 1'b1;
                     end
                     CMD_PRE:
                     begin
                        if (addr[AP_BIT])
                        begin
                           n.open = '0;
                        end
                        else
                        begin
                           n.open[bsel] = 1'b0;
                        end
                        if (s.bact && (addr[AP_BIT] || bsel == s.bbank))
                        begin
                           n.bact = 1'b0;
                        end
                     end
                     CMD_MRS:
                     begin
                        if (s.open == '0 && !s.bact)
                        begin
                           n.mode = ADDR_MAX_W'(addr);
                        end
                     end
                     CMD_BST:
                     begin
                        n.bact = 1'b0;
                     end
                     default:
                     begin
                     end
                  endcase
               end
               n.p1v = beat_rd;
               n.p1d = mem_q;
               n.p2v = s.p1v;
               n.p2d = s.p1d;
               n.m1 = byte_mask;
               n.outd = rd_cl3 ? s.p2d : s.p1d;
               n.oe = {LANES{rd_cl3 ? s.p2v : s.p1v}} & ~s.m1;
            end
         end
         default:
         begin
            n.st = S_RUN;
         end
      endcase
      n.pdown = (n.st == S_PDOWN);
      n.sref = (n.st == S_SREF);
      idx = {bk, col[MEM_CW-1:0]};
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s <= '0;
         s.mode <= MODE_RST;
      end
      else
      begin
         s <= n;
      end
   end

   // ----------------------------------------------------------------
   // Write buffer and storage
   // ----------------------------------------------------------------
   // Reads own the array port, so draining stalls on every read beat.
   // A read that hits data still in the buffer sees the older value.
   sdc_fifo #(
      .WIDTH(FW),
      .DEPTH(WFIFO_DEPTH)
   ) u_wfifo (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .in_valid(push),
      .in_ready(f_in_ready),
      .in_data({byte_mask, idx, data_lines_in}),
      .out_valid(f_out_valid),
      .out_ready(!beat_rd),
      .out_data(f_out)
   );

   assign {f_mask, f_idx, f_data} = f_out;

   // Rows alias onto the same cells; only bank and low column bits index.
   genvar g;
   generate
      for (g = 0; g < LANES; g++)
      begin : g_lane
         logic [LANE_W-1:0] lane_mem [MEM_DEPTH];
         always_ff @(posedge core_clk)
         begin
            if (f_out_valid && !beat_rd && !f_mask[g])
            begin
               lane_mem[f_idx] <= f_data[g*LANE_W +: LANE_W];
            end
         end
         assign mem_q[g*LANE_W +: LANE_W] = lane_mem[idx];
      end
   endgenerate

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign data_lines_out = s.outd;
   assign data_lines_oe = s.oe;
   assign bank_open = s.open;
   assign mode_word = s.mode;
   assign power_down = s.pdown;
   assign self_refresh = s.sref;
   assign clock_suspended = s.susp;
   assign wr_fifo_space = s.wspace;
   assign wr_overrun = s.ovf;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   a_deselect_no_mode: assert property (
      (s.st == S_RUN && clock_gate_in && !live) |=> $stable(mode_word))
      else $error("mode changed without chip select");

   a_act_opens_bank: assert property (
      (s.st == S_RUN && clock_gate_in && live && cmd == CMD_ACT)
      |=> bank_open[$past(bsel)])
      else $error("activate did not open the bank");

   a_pre_all_banks: assert property (
      (s.st == S_RUN && clock_gate_in && live && cmd == CMD_PRE && addr[AP_BIT])
      |=> bank_open == '0)
      else $error("precharge all left a bank open");

   a_mrs_loads_op: assert property (
      (s.st == S_RUN && clock_gate_in && live && cmd == CMD_MRS
       && bank_open == '0 && !s.bact)
      |=> mode_word == ADDR_MAX_W'($past(addr)))
      else $error("mode word not loaded from address");

   a_mask_read_off: assert property (
      (byte_mask[0] && s.st == S_RUN && clock_gate_in)
      ##1 (s.st == S_RUN && clock_gate_in) |=> !data_lines_oe[0])
      else $error("lane driven after read mask");

   a_pdown_ignores_cmd: assert property (
      (power_down && !clock_gate_in)
      |=> $stable(bank_open) && $stable(mode_word) && data_lines_oe == '0)
      else $error("state changed in power-down");

   a_pdown_exit: assert property (
      ((power_down || self_refresh) && clock_gate_in)
      |=> !power_down && !self_refresh)
      else $error("gate high did not end power-down");

   a_suspend_holds: assert property (
      (s.st == S_RUN && s.bact && !clock_gate_in)
      |=> clock_suspended && $stable(s.bcnt) && $stable(data_lines_oe))
      else $error("burst moved while suspended");

   a_burst_steps: assert property (
      (s.st == S_RUN && s.bact && clock_gate_in
       && !(live && (cmd == CMD_RD || cmd == CMD_WR)))
      |=> s.bcnt == $past(s.bcnt) + 9'h001)
      else $error("burst counter did not step");

   a_masked_not_pushed: assert property (
      (push) |-> (byte_mask != '1) && f_in_ready)
      else $error("masked beat pushed into buffer");

endmodule : sdc_cmd_if
`default_nettype wire

// ### src/sdc_pkg.sv
// -----------------------------------------------------------------
// Shared constants of the module command interface
// -----------------------------------------------------------------
package sdc_pkg;

   localparam int DATA_W = 64;
   localparam int LANES = 8;
   localparam int LANE_W = 8;
   localparam int ADDR_MAX_W = 13;
   localparam int COL_MAX_W = 9;
   localparam int BANKS = 4;
   localparam int FIFO_DEPTH = 8;

   // Command codes on {row strobe, column strobe, write strobe}.
   localparam logic [2:0] CMD_MRS = 3'h0;
   localparam logic [2:0] CMD_REF = 3'h1;
   localparam logic [2:0] CMD_PRE = 3'h2;
   localparam logic [2:0] CMD_ACT = 3'h3;
   localparam logic [2:0] CMD_WR = 3'h4;
   localparam logic [2:0] CMD_RD = 3'h5;
   localparam logic [2:0] CMD_BST = 3'h6;

   // Address bit that carries auto precharge or precharge-all.
   localparam int AP_BIT = 10;

   // Mode word fields.
   localparam int BL_LSB = 0;
   localparam int BL_MSB = 2;
   localparam int BT_BIT = 3;
   localparam int CL_LSB = 4;
   localparam int CL_MSB = 6;
   localparam int OPM_LSB = 7;
   localparam int OPM_MSB = 8;
   localparam int WBM_BIT = 9;
   localparam logic [2:0] BL_FULL = 3'h7;
   localparam logic [2:0] CL_THREE = 3'h3;

   // Burst length 1, sequential, read latency 2, normal writes.
   localparam logic [12:0] MODE_RST = 13'h0020;

   typedef enum logic [1:0] {S_RUN, S_PDOWN, S_SREF} sdc_st_t;

endpackage : sdc_pkg

// ### src/sdc_fifo.sv
`timescale 1ns/10ps
`default_nettype none
// -----------------------------------------------------------------
// Write data FIFO, depth must be a power of two
// -----------------------------------------------------------------
module sdc_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
)
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW:0] wp;
      logic [AW:0] rp;
   } sdc_fifo_state_t;

   sdc_fifo_state_t s;
   sdc_fifo_state_t n;
   logic [WIDTH-1:0] mem [DEPTH];

   assign in_ready = !((s.wp[AW] != s.rp[AW]) && (s.wp[AW-1:0] == s.rp[AW-1:0]));
   assign out_valid = (s.wp != s.rp);
   assign out_data = mem[s.rp[AW-1:0]];

   always_comb
   begin
      n = s;
      if (in_valid && in_ready)
      begin
         n.wp = s.wp + 1'b1;
      end
      if (out_valid && out_ready)
      begin
         n.rp = s.rp + 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s <= '0;
      end
      else
      begin
         s <= n;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (in_valid && in_ready)
      begin
         mem[s.wp[AW-1:0]] <= in_data;
      end
   end

endmodule : sdc_fifo
`default_nettype wire

// ### verif/sdc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// Host controller model driving the module's command pins
// ------------------------------------------------------------
module sdc_host_model
   import sdc_pkg::*;
(
   input wire logic core_clk,
   output logic chip_select_lo_n,
   output logic chip_select_hi_n,
   output logic row_strobe_n,
   output logic col_strobe_n,
   output logic write_strobe_n,
   output logic clock_gate_in,
   output logic bank_select_0,
   output logic bank_select_1,
   output logic [12:0] addr,
   output logic [LANES-1:0] byte_mask,
   output logic [DATA_W-1:0] data_lines_in
);

   initial
   begin
      {chip_select_hi_n, chip_select_lo_n} = 2'h3;
      {row_strobe_n, col_strobe_n, write_strobe_n} = 3'h7;
      clock_gate_in = 1'b1;
      {bank_select_1, bank_select_0} = 2'h0;
      addr = 13'h0000;
      byte_mask = 8'h00;
      data_lines_in = 64'h0;
   end

   // Everything changes 1 ns after an edge and holds for the whole cycle.
   // Select is given as {high select, low select}, both active low.
   task automatic cmd(input logic [2:0] code, input logic [1:0] bank, input logic [12:0] a,
         input logic [7:0] m, input logic [63:0] d, input logic gate, input logic [1:0] sel);
      @(posedge core_clk);
      #1;
      {row_strobe_n, col_strobe_n, write_strobe_n} <= code;
      {chip_select_hi_n, chip_select_lo_n} <= sel;
      {bank_select_1, bank_select_0} <= bank;
      addr <= a;
      byte_mask <= m;
      data_lines_in <= d;
      clock_gate_in <= gate;
   endtask : cmd

   // Deselected cycles; released data lines toggle so stale values never look valid.
   task automatic idle(input int n);
      repeat (n) cmd(3'h7, 2'h0, 13'h0000, 8'h00, ~data_lines_in, 1'b1, 2'h3);
   endtask : idle

endmodule : sdc_host_model
`default_nettype wire

// ### verif/test_sdc_cmd_if.sv
`timescale 1ns/10ps
`default_nettype none
module test_sdc_cmd_if;
   import sdc_pkg::*;

   localparam logic [2:0] NOP = 3'h7;
   logic core_clk, arst_n;
   logic chip_select_lo_n, chip_select_hi_n, row_strobe_n, col_strobe_n, write_strobe_n;
   logic clock_gate_in, bank_select_0, bank_select_1;
   logic [12:0] addr;
   logic [7:0] byte_mask, data_lines_oe, m;
   logic [63:0] data_lines_in, data_lines_out;
   logic [3:0] bank_open, c;
   logic [12:0] mode_word;
   logic power_down, self_refresh, clock_suspended, wr_fifo_space, wr_overrun;
   logic [1:0] b;
   logic [63:0] mem [0:63];
   int err_count = 0;
   int samples_checked = 0;
   integer seed;

   sdc_host_model u_sdc_host_model (.core_clk(core_clk), .chip_select_lo_n(chip_select_lo_n),
      .chip_select_hi_n(chip_select_hi_n), .row_strobe_n(row_strobe_n),
      .col_strobe_n(col_strobe_n), .write_strobe_n(write_strobe_n),
      .clock_gate_in(clock_gate_in), .bank_select_0(bank_select_0),
      .bank_select_1(bank_select_1), .addr(addr), .byte_mask(byte_mask),
      .data_lines_in(data_lines_in));

   sdc_cmd_if u_sdc_cmd_if (
      .core_clk(core_clk), .arst_n(arst_n), .chip_select_lo_n(chip_select_lo_n),
      .chip_select_hi_n(chip_select_hi_n), .row_strobe_n(row_strobe_n),
      .col_strobe_n(col_strobe_n), .write_strobe_n(write_strobe_n),
      .clock_gate_in(clock_gate_in), .bank_select_0(bank_select_0),
      .bank_select_1(bank_select_1), .addr(addr), .byte_mask(byte_mask),
      .data_lines_in(data_lines_in), .data_lines_out(data_lines_out),
      .data_lines_oe(data_lines_oe), .bank_open(bank_open), .mode_word(mode_word),
      .power_down(power_down), .self_refresh(self_refresh),
      .clock_suspended(clock_suspended), .wr_fifo_space(wr_fifo_space),
      .wr_overrun(wr_overrun));

   initial
   begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   // ------------------------------------------------------------
   // Expectation helpers
   // ------------------------------------------------------------
   function automatic logic [63:0] merge(input logic [63:0] old, input logic [63:0] nw,
         input logic [7:0] mk);
      logic [63:0] r;
      for (int i = 0; i < LANES; i++)
         r[i*8 +: 8] = mk[i] ? old[i*8 +: 8] : nw[i*8 +: 8];
      return r;
   endfunction : merge

   function automatic logic [63:0] lanes(input logic [7:0] en);
      logic [63:0] r;
      for (int i = 0; i < LANES; i++)
         r[i*8 +: 8] = {8{en[i]}};
      return r;
   endfunction : lanes

   // Burst length 2, sequential: only the lowest column bit steps.
   function automatic logic [3:0] beat_col(input logic [3:0] col, input int k);
      return {col[3:1], col[0] ^ k[0]};
   endfunction : beat_col

   task automatic chk(input logic ok, input string what);
      samples_checked++;
      if (ok !== 1'b1)
      begin
         err_count++;
         $display("unexpected at %0t: %s", $time, what);
      end
   endtask : chk

   task automatic wr2(input logic [1:0] bk, input logic [3:0] col, input logic [63:0] d0,
         input logic [63:0] d1, input logic [7:0] m0, input logic [7:0] m1);
      u_sdc_host_model.cmd(CMD_WR, bk, {9'h000, col}, m0, d0, 1'b1, 2'h2);
      u_sdc_host_model.cmd(NOP, bk, 13'h0000, m1, d1, 1'b1, 2'h2);
      mem[{bk, col}] = merge(mem[{bk, col}], d0, m0);
      mem[{bk, beat_col(col, 1)}] = merge(mem[{bk, beat_col(col, 1)}], d1, m1);
   endtask : wr2

   // Each extra latency cycle puts a shown beat under the mask of one edge later.
   task automatic rd2(input logic [1:0] bk, input logic [3:0] col, input logic [7:0] m0,
         input logic [7:0] m1, input int dl);
      logic [63:0] e;
      logic [7:0] en;
      u_sdc_host_model.cmd(CMD_RD, bk, {9'h000, col}, m0, 64'h0, 1'b1, 2'h2);
      u_sdc_host_model.cmd(NOP, bk, 13'h0000, m1, 64'h0, 1'b1, 2'h2);
      u_sdc_host_model.idle(dl);
      for (int k = 0; k < 2; k++)
      begin
         u_sdc_host_model.idle(1);
         e = mem[{bk, beat_col(col, k)}];
         en = (k + dl == 0) ? ~m0 : ((k + dl == 1) ? ~m1 : 8'hFF);
         chk(data_lines_oe === en, "read lane enables");
         chk(((data_lines_out ^ e) & lanes(en)) === 64'h0, "read data");
      end
   endtask : rd2

   task automatic results;
      $display("comparisons %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : results

   // The whole sequence needs well under 1000 cycles; allow twenty times that.
   initial
   begin
      #160000;
      err_count++;
      $display("unexpected at %0t: watchdog expired", $time);
      results();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      seed = 32'h7D86C5A3;
      arst_n = 1'b0;
      repeat (8) @(posedge core_clk);
      #1;
      arst_n = 1'b1;
      chk(mode_word === MODE_RST && bank_open === 4'h0 && data_lines_oe === 8'h00,
         "reset");
      u_sdc_host_model.cmd(CMD_MRS, 2'h0, 13'h0021, 8'h00, 64'h0, 1'b1, 2'h1);
      u_sdc_host_model.cmd(CMD_ACT, 2'h2, 13'h1ABC, 8'h00, 64'h0, 1'b1, 2'h3);
      u_sdc_host_model.idle(1);
      chk(mode_word === 13'h0021, "mode load");
      chk(bank_open === 4'h0, "deselected activate");
      for (int i = 0; i < BANKS; i++)
         u_sdc_host_model.cmd(CMD_ACT, 2'(i), 13'h1F0F, 8'h00, 64'h0, 1'b1, 2'h2);
      for (int i = 0; i < 32; i++)
         wr2(2'(i / 8), 4'(2 * (i % 8)), {$random(seed), $random(seed)},
            {$random(seed), $random(seed)}, 8'h00, 8'h00);
      chk(wr_fifo_space === 1'b1 && wr_overrun === 1'b0, "buffer keeps up");
      u_sdc_host_model.cmd(CMD_MRS, 2'h0, 13'h0022, 8'h00, 64'h0, 1'b1, 2'h2);
      u_sdc_host_model.idle(3);
      chk(mode_word === 13'h0021 && bank_open === 4'hF, "mode load refused");
      for (int i = 0; i < 12; i++)
      begin
         b = 2'($random(seed));
         c = 4'($random(seed));
         m = (i == 0) ? 8'hFF : 8'($random(seed));
         wr2(b, c, {$random(seed), $random(seed)}, {$random(seed), $random(seed)}, m, ~m);
         u_sdc_host_model.idle(3);
         rd2(b, c, (i == 1) ? 8'hFF : 8'($random(seed)), 8'h00, 0);
      end
      chk(wr_fifo_space === 1'b1 && wr_overrun === 1'b0, "write buffer state");
      u_sdc_host_model.cmd(CMD_PRE, 2'h1, 13'h0000, 8'h00, 64'h0, 1'b1, 2'h2);
      u_sdc_host_model.idle(1);
      chk(bank_open === 4'hD, "single bank precharge");
      u_sdc_host_model.cmd(CMD_PRE, 2'h0, 13'h0400, 8'h00, 64'h0, 1'b1, 2'h2);
      u_sdc_host_model.idle(1);
      chk(bank_open === 4'h0, "all bank precharge");
      u_sdc_host_model.cmd(CMD_ACT, 2'h3, 13'h0123, 8'h00, 64'h0, 1'b1, 2'h2);
      u_sdc_host_model.cmd(CMD_RD, 2'h3, 13'h0405, 8'h00, 64'h0, 1'b1, 2'h2);
      u_sdc_host_model.idle(6);
      chk(bank_open === 4'h0 && data_lines_oe === 8'h00, "auto precharge");
      // Latency three with interleaved bursts, then the bank is closed again.
      u_sdc_host_model.cmd(CMD_MRS, 2'h0, 13'h0039, 8'h00, 64'h0, 1'b1, 2'h2);
      u_sdc_host_model.cmd(CMD_ACT, 2'h2, 13'h0777, 8'h00, 64'h0, 1'b1, 2'h2);
      chk(mode_word === 13'h0039, "latency three mode");
      c = 4'($random(seed));
      m = 8'($random(seed));
      wr2(2'h2, c, {$random(seed), $random(seed)}, {$random(seed), $random(seed)}, m, ~m);
      u_sdc_host_model.idle(3);
      rd2(2'h2, c, 8'($random(seed)), 8'($random(seed)), 1);
      u_sdc_host_model.cmd(CMD_PRE, 2'h2, 13'h0400, 8'h00, 64'h0, 1'b1, 2'h2);
      u_sdc_host_model.cmd(NOP, 2'h0, 13'h0000, 8'h00, 64'h0, 1'b0, 2'h2);
      u_sdc_host_model.cmd(CMD_ACT, 2'h1, 13'h0000, 8'h00, 64'h0, 1'b0, 2'h2);
      chk(power_down === 1'b1, "power-down entry");
      u_sdc_host_model.cmd(NOP, 2'h0, 13'h0000, 8'h00, 64'h0, 1'b0, 2'h2);
      chk(power_down === 1'b1 && bank_open === 4'h0, "command ignored in power-down");
      u_sdc_host_model.idle(2);
      chk(power_down === 1'b0, "power-down exit");
      u_sdc_host_model.cmd(CMD_REF, 2'h0, 13'h0000, 8'h00, 64'h0, 1'b0, 2'h2);
      u_sdc_host_model.cmd(NOP, 2'h0, 13'h0000, 8'h00, 64'h0, 1'b0, 2'h2);
      chk(self_refresh === 1'b1, "self refresh entry");
      u_sdc_host_model.idle(2);
      chk(self_refresh === 1'b0, "self refresh exit");
      u_sdc_host_model.cmd(CMD_ACT, 2'h0, 13'h0000, 8'h00, 64'h0, 1'b1, 2'h2);
      u_sdc_host_model.cmd(CMD_RD, 2'h0, 13'h0002, 8'h00, 64'h0, 1'b1, 2'h2);
      u_sdc_host_model.cmd(NOP, 2'h0, 13'h0000, 8'h00, 64'h0, 1'b0, 2'h2);
      u_sdc_host_model.cmd(NOP, 2'h0, 13'h0000, 8'h00, 64'h0, 1'b0, 2'h2);
      chk(clock_suspended === 1'b1, "clock suspend entry");
      u_sdc_host_model.idle(2);
      chk(clock_suspended === 1'b0, "clock suspend exit");
      u_sdc_host_model.cmd(CMD_BST, 2'h0, 13'h0000, 8'h00, 64'h0, 1'b1, 2'h2);
      u_sdc_host_model.idle(4);
      chk(data_lines_oe === 8'h00 && bank_open === 4'h1, "burst stop");
      // A second reset in mid-run must restore the mode word and close every bank.
      arst_n = 1'b0;
      #1;
      chk(mode_word === MODE_RST && bank_open === 4'h0, "mid-run reset");
      u_sdc_host_model.idle(1);
      arst_n = 1'b1;
      u_sdc_host_model.cmd(CMD_ACT, 2'h1, 13'h0000, 8'h00, 64'h0, 1'b1, 2'h1);
      u_sdc_host_model.idle(1);
      chk(bank_open === 4'h2 && mode_word === MODE_RST, "command after reset");
      results();
   end

endmodule : test_sdc_cmd_if
`default_nettype wire
